//--- pkg/eirq_defs.svh
`ifndef EIRQ_DEFS_SVH
`define EIRQ_DEFS_SVH

// ==========================================================================
// Register byte offsets on the APB.
`define EIRQ_CS_OFF 8'h00
`define EIRQ_IST_OFF 8'h04
`define EIRQ_IMSK_OFF 8'h08
`define EIRQ_PEND_OFF 8'h0c

// ==========================================================================
// Bit positions in the pin request control and status register.
`define EIRQ_B_MODE 0
`define EIRQ_B_IE 1
`define EIRQ_B_ACK 2
`define EIRQ_B_FLAG 3
`define EIRQ_B_PE 4
`define EIRQ_B_POL 5
`define EIRQ_B_PDD 6

// ==========================================================================
// Bit positions in the sticky event status and mask registers.
`define EIRQ_IST_PIN 0
`define EIRQ_IST_SEQ 1
`define EIRQ_IST_W 2

// ==========================================================================
// Vector table layout.
`define EIRQ_VEC_BASE 16'hffc0
`define EIRQ_VEC_LOWEST 5'd31
`define EIRQ_VEC_PIN 2
`define EIRQ_HW_VEC_MASK 32'h3fff_ffff
`define EIRQ_NUM_VEC 32

`endif

//--- pkg/eirq_pkg.sv
package eirq_pkg;

    typedef logic [4:0] eirq_vec_t;

    // Interrupt entry sequence; the code is shown to the CPU as its step.
    typedef enum logic [3:0] {
        SQ_IDLE = 4'b0000,
        SQ_PCL = 4'b0001,
        SQ_PCH = 4'b0010,
        SQ_X = 4'b0011,
        SQ_A = 4'b0100,
        SQ_CCR = 4'b0101,
        SQ_MASK = 4'b0110,
        SQ_FETCH_HI = 4'b0111,
        SQ_FETCH_LO = 4'b1000
    } eirq_seq_e;

endpackage

//--- hdl/eirq_sync.sv
`timescale 1ns/1ps
// ==========================================================================
// Three-stage pin synchroniser with agreement filter.
module eirq_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic level_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // The first stage feeds only the second, to keep metastability contained.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change is accepted only when the second and third stages agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_out <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
        end
    end
endmodule

//--- hdl/eirq_top.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "eirq_defs.svh"
// ==========================================================================
module eirq_top (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic IRQ_PIN_IN,
    output logic PULL_UP_EN,
    output logic PULL_DOWN_EN,
    output logic PIN_LEVEL,
    output logic PIN_LEVEL_VALID,
    input wire logic [31:0] SRC_FLAG,
    input wire logic [31:0] SRC_ENABLE,
    input wire logic CPU_IMASK,
    input wire logic CPU_INSTR_DONE,
    output logic CPU_REQ,
    output eirq_pkg::eirq_vec_t VEC_NUM,
    output logic [3:0] SEQ_STEP,
    output logic [15:0] SEQ_ADDR,
    output logic CPU_SET_IMASK,
    output logic INT_OUT
);
    import eirq_pkg::*;

    // ======================================================================
    // Declarations.
    logic pin_request_enable_reg;
    logic request_polarity_select_reg;
    logic edge_level_mode_select_reg;
    logic pull_device_disable_reg;
    logic pin_request_int_enable_reg;
    logic pin_request_flag_reg;
    logic [`EIRQ_IST_W-1:0] int_status_reg;
    logic [`EIRQ_IST_W-1:0] int_mask_reg;
    logic pin_sync;
    logic asserted_now;
    logic asserted_prev_reg;
    logic pin_edge;
    logic wr_fire;
    logic rd_fire;
    logic addr_ok;
    logic ack_write;
    logic [31:0] rdata_next;
    logic [31:0] pending;
    logic any_pending;
    eirq_vec_t best_vec;
    eirq_vec_t vec_latched_reg;
    eirq_seq_e seq_reg;
    eirq_seq_e seq_next;
    logic [15:0] slot_addr;
    logic [`EIRQ_IST_W-1:0] ist_set;

    // ======================================================================
    // Pin sampling.
    // The pin is asynchronous to MCLK, so it passes the filtered synchroniser.
    eirq_sync u_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .async_in(IRQ_PIN_IN),
        .level_out(pin_sync)
    );

    // Polarity maps the pin to an asserted level; high polarity means rising.
    assign asserted_now = request_polarity_select_reg ? pin_sync : ~pin_sync;

    // Previous asserted state is forced deasserted while disabled, so enabling
    // the pin with it already asserted counts as an edge.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            asserted_prev_reg <= 1'b1;
        end else if (pin_request_enable_reg) begin
            asserted_prev_reg <= asserted_now;
        end else begin
            asserted_prev_reg <= 1'b0;
        end
    end

    // Edge seen only while the pin function is enabled.
    assign pin_edge = pin_request_enable_reg & asserted_now & ~asserted_prev_reg;

    // ======================================================================
    // APB slave.
    // The slave inserts one wait state: pready rises in the second access cycle.
    assign wr_fire = PSEL & PENABLE & PREADY & PWRITE;
    assign rd_fire = PSEL & PENABLE & ~PREADY & ~PWRITE;
    assign addr_ok = (PADDR == `EIRQ_CS_OFF) | (PADDR == `EIRQ_IST_OFF) |
        (PADDR == `EIRQ_IMSK_OFF) | (PADDR == `EIRQ_PEND_OFF);
    assign ack_write = wr_fire & (PADDR == `EIRQ_CS_OFF) & PWDATA[`EIRQ_B_ACK];

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= PSEL & PENABLE & ~PREADY;
        end
    end

    // Unmapped addresses answer with an error in the ready cycle.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PSLVERR <= 1'b0;
        end else begin
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
        end
    end

    // Read mux; the acknowledge bit always reads as zero.
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (PADDR)
            `EIRQ_CS_OFF: begin
                rdata_next[`EIRQ_B_PDD] = pull_device_disable_reg;
                rdata_next[`EIRQ_B_POL] = request_polarity_select_reg;
                rdata_next[`EIRQ_B_PE] = pin_request_enable_reg;
                rdata_next[`EIRQ_B_FLAG] = pin_request_flag_reg;
                rdata_next[`EIRQ_B_ACK] = 1'b0;
                rdata_next[`EIRQ_B_IE] = pin_request_int_enable_reg;
                rdata_next[`EIRQ_B_MODE] = edge_level_mode_select_reg;
            end
            `EIRQ_IST_OFF: begin
                rdata_next[`EIRQ_IST_W-1:0] = int_status_reg;
            end
            `EIRQ_IMSK_OFF: begin
                rdata_next[`EIRQ_IST_W-1:0] = int_mask_reg;
            end
            `EIRQ_PEND_OFF: begin
                rdata_next = pending;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_fire) begin
            PRDATA <= rdata_next;
        end
    end

    // ======================================================================
    // Pin configuration bits.
    // All configuration returns to the disabled default on reset.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pin_request_enable_reg <= 1'b0;
            request_polarity_select_reg <= 1'b0;
            edge_level_mode_select_reg <= 1'b0;
            pull_device_disable_reg <= 1'b0;
            pin_request_int_enable_reg <= 1'b0;
        end else if (wr_fire && PADDR == `EIRQ_CS_OFF) begin
            pin_request_enable_reg <= PWDATA[`EIRQ_B_PE];
            request_polarity_select_reg <= PWDATA[`EIRQ_B_POL];
            edge_level_mode_select_reg <= PWDATA[`EIRQ_B_MODE];
            pull_device_disable_reg <= PWDATA[`EIRQ_B_PDD];
            pin_request_int_enable_reg <= PWDATA[`EIRQ_B_IE];
        end
    end

    // ======================================================================
    // Request flag.
    // A new edge wins over an acknowledge in the same cycle, and in level mode
    // an asserted pin keeps the flag set so a clear is refused.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pin_request_flag_reg <= 1'b0;
        end else if (pin_edge) begin
            pin_request_flag_reg <= 1'b1;
        end else if (pin_request_enable_reg && edge_level_mode_select_reg &&
                asserted_now) begin
            pin_request_flag_reg <= 1'b1;
        end else if (ack_write) begin
            pin_request_flag_reg <= 1'b0;
        end
    end

    // ======================================================================
    // Pull device and pin level.
    // The pull follows polarity: pullup for falling, pulldown for rising.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PULL_UP_EN <= 1'b0;
            PULL_DOWN_EN <= 1'b0;
        end else begin
            PULL_UP_EN <= pin_request_enable_reg & ~pull_device_disable_reg &
                ~request_polarity_select_reg;
            PULL_DOWN_EN <= pin_request_enable_reg & ~pull_device_disable_reg &
                request_polarity_select_reg;
        end
    end

    // The level is the raw synchronised pin, valid only while configured.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PIN_LEVEL <= 1'b0;
            PIN_LEVEL_VALID <= 1'b0;
        end else begin
            PIN_LEVEL <= pin_sync & pin_request_enable_reg;
            PIN_LEVEL_VALID <= pin_request_enable_reg;
        end
    end

    // ======================================================================
    // Pending vectors and priority.
    // Only flags with their local enable set are forwarded; the pin source
    // replaces slot two and the two lowest slots are never requested.
    always_comb begin
        pending = SRC_FLAG & SRC_ENABLE;
        pending[`EIRQ_VEC_PIN] = pin_request_flag_reg & pin_request_int_enable_reg;
        pending = pending & `EIRQ_HW_VEC_MASK;
    end

    assign any_pending = |pending;

    // Scan from the lowest slot down so the lowest set number is kept.
    always_comb begin
        best_vec = `EIRQ_VEC_LOWEST;
        for (int i = `EIRQ_NUM_VEC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                best_vec = 5'(i);
            end
        end
    end

    // Slot of vector n sits 2*(31-n) bytes above the table base.
    assign slot_addr = `EIRQ_VEC_BASE +
        {10'h000, 5'(`EIRQ_VEC_LOWEST - vec_latched_reg), 1'b0};

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            CPU_REQ <= 1'b0;
            VEC_NUM <= 5'h00;
        end else begin
            CPU_REQ <= any_pending & ~CPU_IMASK;
            VEC_NUM <= best_vec;
        end
    end

    // ======================================================================
    // Interrupt entry sequence.
    // Priority is frozen when the sequence starts, so a late higher request
    // waits for the next entry rather than tearing the vector fetch.
    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            SQ_IDLE: begin
                if (any_pending && !CPU_IMASK && CPU_INSTR_DONE) begin
                    seq_next = SQ_PCL;
                end
            end
            // Stacking, the mask step and the high fetch follow in code order,
            // one step per cycle, so the CPU sees no gaps in the walk.
            SQ_PCL, SQ_PCH, SQ_X, SQ_A, SQ_CCR, SQ_MASK, SQ_FETCH_HI: begin
                seq_next = eirq_seq_e'(seq_reg + 4'h1);
            end
            SQ_FETCH_LO: begin
                seq_next = SQ_IDLE;
            end
            default: begin
                seq_next = SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            seq_reg <= SQ_IDLE;
        end else begin
            seq_reg <= seq_next;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            vec_latched_reg <= 5'h00;
        end else if (seq_reg == SQ_IDLE && seq_next == SQ_PCL) begin
            vec_latched_reg <= best_vec;
        end
    end

    // Step and address are registered copies of the next state.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            SEQ_STEP <= 4'h0;
            SEQ_ADDR <= 16'h0000;
            CPU_SET_IMASK <= 1'b0;
        end else begin
            SEQ_STEP <= seq_next;
            CPU_SET_IMASK <= (seq_next == SQ_MASK);
            if (seq_next == SQ_FETCH_HI) begin
                SEQ_ADDR <= slot_addr;
            end else if (seq_next == SQ_FETCH_LO) begin
                SEQ_ADDR <= slot_addr | 16'h0001;
            end else begin
                SEQ_ADDR <= 16'h0000;
            end
        end
    end

    // ======================================================================
    // Event status, mask and interrupt line.
    // Hardware set wins over a write-one clear in the same cycle.
    always_comb begin
        ist_set = '0;
        ist_set[`EIRQ_IST_PIN] = pin_edge;
        ist_set[`EIRQ_IST_SEQ] = (seq_reg == SQ_FETCH_LO);
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            int_status_reg <= '0;
        end else if (wr_fire && PADDR == `EIRQ_IST_OFF) begin
            int_status_reg <= (int_status_reg & ~PWDATA[`EIRQ_IST_W-1:0]) | ist_set;
        end else begin
            int_status_reg <= int_status_reg | ist_set;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            int_mask_reg <= '0;
        end else if (wr_fire && PADDR == `EIRQ_IMSK_OFF) begin
            int_mask_reg <= PWDATA[`EIRQ_IST_W-1:0];
        end
    end

    // One cycle late relative to the status bit, to keep the output a flop.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            INT_OUT <= 1'b0;
        end else begin
            INT_OUT <= |(int_status_reg & int_mask_reg);
        end
    end
endmodule

//--- bench/eirq_pin_src.sv
`timescale 1ns/1ps
// ==========================================================================
// External request source that stands on the far side of the request pin.
module eirq_pin_src (
    input wire logic clk,
    input wire logic drive_en,
    input wire logic drive_val,
    input wire logic pull_up,
    input wire logic pull_down,
    output logic pin
);
    logic float_reg = 1'b0;

    // A released pin with no pull shows a changing pattern, so no stale level looks valid.
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    // A driven level wins over the pull device; the pull wins over a floating pin.
    always_comb begin
        if (drive_en) begin
            pin = drive_val;
        end else if (pull_up) begin
            pin = 1'b1;
        end else if (pull_down) begin
            pin = 1'b0;
        end else begin
            pin = float_reg;
        end
    end
endmodule

//--- bench/eirq_checker.sv
`timescale 1ns/1ps
// ==========================================================================
// Port-level checker for the pin request and vector block.
module eirq_checker (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic PULL_UP_EN,
    input wire logic PULL_DOWN_EN,
    input wire logic PIN_LEVEL,
    input wire logic PIN_LEVEL_VALID,
    input wire logic CPU_IMASK,
    input wire logic CPU_INSTR_DONE,
    input wire logic CPU_REQ,
    input wire eirq_pkg::eirq_vec_t VEC_NUM,
    input wire logic [3:0] SEQ_STEP,
    input wire logic [15:0] SEQ_ADDR,
    input wire logic CPU_SET_IMASK
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    // Entry walk: stacking steps, then mask and the two vector fetches.
    sequence s_stack;
        SEQ_STEP == 4'd2 ##1 SEQ_STEP == 4'd3 ##1 SEQ_STEP == 4'd4 ##1 SEQ_STEP == 4'd5;
    endsequence
    sequence s_fetch;
        SEQ_STEP == 4'd6 ##1 SEQ_STEP == 4'd7 ##1 SEQ_STEP == 4'd8 ##1 SEQ_STEP == 4'd0;
    endsequence

    property p_ready_wait;
        PSEL && PENABLE && !PREADY |=> PREADY;
    endproperty
    property p_err_ready;
        PSLVERR |-> PREADY && PSEL && PENABLE;
    endproperty
    property p_pull_excl;
        !(PULL_UP_EN && PULL_DOWN_EN);
    endproperty
    property p_pull_gated;
        (PULL_UP_EN || PULL_DOWN_EN) |-> PIN_LEVEL_VALID;
    endproperty
    property p_level_gated;
        !PIN_LEVEL_VALID |-> !PIN_LEVEL;
    endproperty
    property p_no_user_vec;
        CPU_REQ |-> VEC_NUM <= 5'd29;
    endproperty
    property p_req_mask;
        CPU_REQ |-> !$past(CPU_IMASK);
    endproperty
    property p_entry_start;
        SEQ_STEP == 4'd1 |-> $past(!CPU_IMASK && CPU_INSTR_DONE);
    endproperty
    property p_entry_walk;
        SEQ_STEP == 4'd1 |=> s_stack ##1 s_fetch;
    endproperty
    property p_mask_pulse;
        CPU_SET_IMASK == (SEQ_STEP == 4'd6);
    endproperty
    property p_addr_pair;
        SEQ_STEP == 4'd7 |-> !SEQ_ADDR[0] && SEQ_ADDR >= 16'hffc4
            ##1 SEQ_ADDR == $past(SEQ_ADDR) + 16'h1;
    endproperty
    property p_ack_reads0;
        PSEL && PENABLE && PREADY && !PWRITE && PADDR == 8'h00 |-> !PRDATA[2];
    endproperty

    a_ready_wait: assert property (p_ready_wait) else $error("ready not given in access");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
    a_pull_gated: assert property (p_pull_gated) else $error("pull on with pin off");
    a_level_gated: assert property (p_level_gated) else $error("level shown when off");
    a_no_user_vec: assert property (p_no_user_vec) else $error("user vector raised");
    a_req_mask: assert property (p_req_mask) else $error("request while masked");
    a_entry_start: assert property (p_entry_start) else $error("entry without cause");
    a_entry_walk: assert property (p_entry_walk) else $error("entry order wrong");
    a_mask_pulse: assert property (p_mask_pulse) else $error("mask pulse misplaced");
    a_addr_pair: assert property (p_addr_pair) else $error("vector fetch order wrong");
    a_ack_reads0: assert property (p_ack_reads0) else $error("ack bit read as one");
endmodule

bind eirq_top eirq_checker u_chk (
    .MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN), .PIN_LEVEL(PIN_LEVEL),
    .PIN_LEVEL_VALID(PIN_LEVEL_VALID), .CPU_IMASK(CPU_IMASK),
    .CPU_INSTR_DONE(CPU_INSTR_DONE), .CPU_REQ(CPU_REQ), .VEC_NUM(VEC_NUM),
    .SEQ_STEP(SEQ_STEP), .SEQ_ADDR(SEQ_ADDR), .CPU_SET_IMASK(CPU_SET_IMASK)
);

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "eirq_defs.svh"
// ==========================================================================
// Self-checking bench: APB tasks, a pin source and CPU-side stimulus.
module testbench;
    import eirq_pkg::*;
    localparam logic [31:0] mode = 32'h1 << `EIRQ_B_MODE;
    localparam logic [31:0] ie = 32'h1 << `EIRQ_B_IE;
    localparam logic [31:0] ack = 32'h1 << `EIRQ_B_ACK;
    localparam logic [31:0] flag = 32'h1 << `EIRQ_B_FLAG;
    localparam logic [31:0] pe = 32'h1 << `EIRQ_B_PE;
    localparam logic [31:0] pol = 32'h1 << `EIRQ_B_POL;
    localparam logic [31:0] pdd = 32'h1 << `EIRQ_B_PDD;
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, src_flag = 32'h0, src_en = 32'h0;
    logic pready, pslverr, pin, pull_up_en, pull_down_en, pin_level, pin_level_valid;
    logic cpu_imask = 1'b1, cpu_instr_done = 1'b0, cpu_req, cpu_set_imask, int_out;
    logic drive_en = 1'b1, drive_val = 1'b1, err;
    logic [31:0] q;
    logic [3:0] seq_step;
    logic [15:0] seq_addr;
    eirq_vec_t vec_num;
    int failures = 0, n_compared = 0;

    // Free-running 125 MHz clock.
    initial begin
        forever #4 mclk = ~mclk;
    end

    eirq_top dut (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IRQ_PIN_IN(pin), .PULL_UP_EN(pull_up_en), .PULL_DOWN_EN(pull_down_en),
        .PIN_LEVEL(pin_level), .PIN_LEVEL_VALID(pin_level_valid), .SRC_FLAG(src_flag),
        .SRC_ENABLE(src_en), .CPU_IMASK(cpu_imask), .CPU_INSTR_DONE(cpu_instr_done),
        .CPU_REQ(cpu_req), .VEC_NUM(vec_num), .SEQ_STEP(seq_step), .SEQ_ADDR(seq_addr),
        .CPU_SET_IMASK(cpu_set_imask), .INT_OUT(int_out));

    eirq_pin_src u_src (.clk(mclk), .drive_en(drive_en), .drive_val(drive_val),
        .pull_up(pull_up_en), .pull_down(pull_down_en), .pin(pin));

    // ======================================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Called just after a rising edge; holds the request until ready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // The slave sets the pace; only the watchdog ends a wait that never ends.
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        #(8 * 4000);
        failures++;
        wrap_up();
    end

    // ======================================================================
    // Main sequence
    initial begin
        tick(2);
        nrst <= 1'b1;
        @(posedge mclk);
        rd("ctrl at reset", `EIRQ_CS_OFF, 32'h0);
        rd("pending at reset", `EIRQ_PEND_OFF, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        apb(1'b1, `EIRQ_CS_OFF, pe | ie);
        tick(8);
        chk("pull up", 32'h1, 32'(pull_up_en));
        chk("pull down", 32'h0, 32'(pull_down_en));
        drive_en <= 1'b0;
        tick(8);
        chk("pulled level", 32'h1, 32'(pin_level));
        drive_en <= 1'b1;
        apb(1'b1, `EIRQ_CS_OFF, pe | ie | pdd);
        // The pull output is a flop behind the written bit, so give it two cycles.
        tick(2);
        chk("pull off", 32'h0, 32'(pull_up_en));
        apb(1'b1, `EIRQ_CS_OFF, pe | ie);
        apb(1'b1, `EIRQ_IMSK_OFF, 32'h1);
        cpu_imask <= 1'b0;
        drive_val <= 1'b0;
        tick(8);
        rd("flag on fall", `EIRQ_CS_OFF, pe | ie | flag);
        chk("level low", 32'h0, 32'(pin_level));
        chk("request", 32'h1, 32'(cpu_req));
        chk("pin vector", 32'd2, 32'(vec_num));
        chk("irq out", 32'h1, 32'(int_out));
        // Entry walk after an instruction boundary.
        cpu_instr_done <= 1'b1;
        @(posedge mclk);
        cpu_instr_done <= 1'b0;
        for (int i = 1; i <= 8; i++) begin
            @(posedge mclk);
            chk("entry step", 32'(i), 32'(seq_step));
            chk("mask pulse", 32'(i == 6), 32'(cpu_set_imask));
            if (i >= 7) chk("vector addr", 32'hfff3 + 32'(i), 32'(seq_addr));
        end
        cpu_imask <= 1'b1;
        tick(2);
        rd("status", `EIRQ_IST_OFF, 32'h3);
        apb(1'b1, `EIRQ_IMSK_OFF, 32'h0);
        // The interrupt line trails the mask register by one flop.
        tick(2);
        chk("irq masked", 32'h0, 32'(int_out));
        apb(1'b1, `EIRQ_IST_OFF, 32'h3);
        rd("status cleared", `EIRQ_IST_OFF, 32'h0);
        apb(1'b1, `EIRQ_CS_OFF, pe | ie | ack);
        rd("ack edge mode", `EIRQ_CS_OFF, pe | ie);
        // Level mode holds the flag while the pin stays asserted.
        apb(1'b1, `EIRQ_CS_OFF, pe | ie | mode | ack);
        rd("level held", `EIRQ_CS_OFF, pe | ie | mode | flag);
        drive_val <= 1'b1;
        tick(8);
        apb(1'b1, `EIRQ_CS_OFF, pe | ie | mode | ack);
        rd("level released", `EIRQ_CS_OFF, pe | ie | mode);
        // Rising polarity in polled mode.
        drive_val <= 1'b0;
        tick(8);
        apb(1'b1, `EIRQ_CS_OFF, pe | pol);
        apb(1'b1, `EIRQ_CS_OFF, pe | pol | ack);
        chk("pull down", 32'h1, 32'(pull_down_en));
        drive_val <= 1'b1;
        tick(8);
        rd("flag on rise", `EIRQ_CS_OFF, pe | pol | flag);
        rd("polled only", `EIRQ_PEND_OFF, 32'h0);
        apb(1'b1, `EIRQ_CS_OFF, pe | pol | ack);
        // Disabled pin is ignored.
        apb(1'b1, `EIRQ_CS_OFF, 32'h0);
        drive_val <= 1'b0;
        tick(8);
        drive_val <= 1'b1;
        tick(8);
        rd("pin off", `EIRQ_CS_OFF, 32'h0);
        chk("level hidden", 32'h0, 32'(pin_level_valid));
        // Priority among the other sources.
        cpu_imask <= 1'b0;
        src_flag <= 32'hc000_0220;
        src_en <= 32'hffff_ffff;
        tick(3);
        chk("priority", 32'd5, 32'(vec_num));
        rd("pending", `EIRQ_PEND_OFF, 32'h0000_0220);
        src_en <= 32'hffff_ffdf;
        tick(3);
        chk("local enable", 32'd9, 32'(vec_num));
        src_flag <= 32'hc000_0000;
        tick(3);
        chk("user slots", 32'h0, 32'(cpu_req));
        chk("no vector", 32'd31, 32'(vec_num));
        wrap_up();
    end
endmodule
